//--- sbrg_pkg.sv
// Contract
// - One rate from the control register drives both receiver and transmitter.
// - Prescaler select codes 00,01,10,11 divide by 1,3,4,13.
// - Reset clears both select fields; both are software readable and writable.
// - Divisor select code n divides by two to the power n.
// - Bit rate equals clock over 64 times prescaler times binary divisor.
// =====================================================================
// Shared constants and types
// =====================================================================
package sbrg_pkg;
   localparam int ADDR_W = 12;
   localparam logic [11:0] RATE_CTRL_OFFSET = 12'h000;
   localparam logic [11:0] RATE_STATUS_OFFSET = 12'h004;
   localparam int PRESCALER_LO_POS = 3;
   localparam int PRESCALER_HI_POS = 4;
   localparam int RATE_DIV_POS = 0;
   localparam logic [7:0] RATE_CTRL_RESET = 8'h00;
   // Sixteen ticks per bit, so 64 splits into 16 x 4
   localparam int OVERSAMPLE = 16;
   localparam logic [5:0] BASE_DIV = 6'h04;
   localparam logic [5:0] PD_CODE0 = 6'h01;
   localparam logic [5:0] PD_CODE1 = 6'h03;
   localparam logic [5:0] PD_CODE2 = 6'h04;
   localparam logic [5:0] PD_CODE3 = 6'h0d;

   typedef struct packed {
      logic prescaler_select_hi;
      logic prescaler_select_lo;
      logic [2:0] rate_divisor_select;
   } sbrg_sel_s;
endpackage

//--- sbrg_top.sv
`timescale 1ns/1ps
module sbrg_top (
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic RESET,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [sbrg_pkg::ADDR_W-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [3:0] PSTRB,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Rate ticks to receiver and transmitter
   output logic RX_SAMPLE_TICK,
   output logic TX_BIT_TICK
);
   // =====================================================================
   // Register bus
   // =====================================================================
   sbrg_pkg::sbrg_sel_s sel, next_sel;
   logic [31:0] next_prdata;
   logic next_pready, next_pslverr;
   logic access, hit_ctrl, hit_status, wr_ctrl, reload;
   logic [3:0] os_cnt, next_os_cnt;

   assign hit_ctrl = (PADDR == sbrg_pkg::RATE_CTRL_OFFSET);
   assign hit_status = (PADDR == sbrg_pkg::RATE_STATUS_OFFSET);
   // Write lands only on the edge where the master sees PREADY high
   assign access = PSEL && PENABLE && PREADY;
   assign wr_ctrl = access && PWRITE && hit_ctrl && PSTRB[0];
   assign reload = wr_ctrl && (PWDATA[4:0] != sel);

   always_comb
   begin
      next_sel = sel;
      if (wr_ctrl)
      begin
         next_sel = PWDATA[4:0];
      end
      next_pready = PSEL && PENABLE && !PREADY;
      next_pslverr = next_pready && !hit_ctrl && !hit_status;
      next_prdata = 32'h0000_0000;
      if (next_pready && !PWRITE && hit_ctrl)
      begin
         next_prdata = {27'h000_0000, sel};
      end
      else if (next_pready && !PWRITE && hit_status)
      begin
         next_prdata = {28'h000_0000, os_cnt};
      end
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (RESET)
      begin
         sel <= sbrg_pkg::RATE_CTRL_RESET[4:0];
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA <= 32'h0000_0000;
      end
      else
      begin
         sel <= next_sel;
         PREADY <= next_pready;
         PSLVERR <= next_pslverr;
         PRDATA <= next_prdata;
      end
   end

   // =====================================================================
   // Rate divider
   // =====================================================================
   logic [5:0] pd, pre_last, pre_cnt, next_pre_cnt;
   logic [6:0] bd_cnt, next_bd_cnt, bd_last;
   logic pre_end, bd_end, next_rx, next_tx;

   always_comb
   begin
      case ({sel.prescaler_select_hi, sel.prescaler_select_lo})
         2'h0: pd = sbrg_pkg::PD_CODE0;
         2'h1: pd = sbrg_pkg::PD_CODE1;
         2'h2: pd = sbrg_pkg::PD_CODE2;
         2'h3: pd = sbrg_pkg::PD_CODE3;
         default: pd = sbrg_pkg::PD_CODE0;
      endcase
   end

   // 4 x PD fits in six bits: 52 at most
   assign pre_last = 6'((pd * sbrg_pkg::BASE_DIV) - 6'h01);
   assign bd_last = 7'((8'h01 << sel.rate_divisor_select) - 8'h01);
   assign pre_end = (pre_cnt == pre_last);
   assign bd_end = (bd_cnt == bd_last);

   always_comb
   begin
      next_pre_cnt = pre_end ? 6'h00 : 6'(pre_cnt + 6'h01);
      next_bd_cnt = bd_cnt;
      next_os_cnt = os_cnt;
      next_rx = 1'b0;
      next_tx = 1'b0;
      if (pre_end)
      begin
         next_bd_cnt = bd_end ? 7'h00 : 7'(bd_cnt + 7'h01);
      end
      if (pre_end && bd_end)
      begin
         next_rx = 1'b1;
         next_os_cnt = 4'(os_cnt + 4'h1);
         next_tx = (os_cnt == 4'(sbrg_pkg::OVERSAMPLE - 1));
      end
      // A new rate restarts cleanly rather than finishing an old period
      if (reload)
      begin
         next_pre_cnt = 6'h00;
         next_bd_cnt = 7'h00;
         next_os_cnt = 4'h0;
         next_rx = 1'b0;
         next_tx = 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (RESET)
      begin
         pre_cnt <= 6'h00;
         bd_cnt <= 7'h00;
         os_cnt <= 4'h0;
         RX_SAMPLE_TICK <= 1'b0;
         TX_BIT_TICK <= 1'b0;
      end
      else
      begin
         pre_cnt <= next_pre_cnt;
         bd_cnt <= next_bd_cnt;
         os_cnt <= next_os_cnt;
         RX_SAMPLE_TICK <= next_rx;
         TX_BIT_TICK <= next_tx;
      end
   end

   // =====================================================================
   // Checks
   // =====================================================================
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RESET);

   logic [13:0] gap, per_cyc;
   logic seen, rst_d;
   assign per_cyc = 14'(pd * sbrg_pkg::BASE_DIV) << sel.rate_divisor_select;
   always_ff @(posedge CORE_CLK)
   begin
      rst_d <= RESET;
      gap <= RX_SAMPLE_TICK ? 14'h0001 : 14'(gap + 14'h0001);
      seen <= (RESET || reload) ? 1'b0 : (RX_SAMPLE_TICK ? 1'b1 : seen);
   end

   property p_tx_on_rx;
      TX_BIT_TICK |-> RX_SAMPLE_TICK;
   endproperty
   a_tx_on_rx: assert property (p_tx_on_rx) else $error("Bit tick without sample tick");

   property p_tx_every16;
      TX_BIT_TICK |-> os_cnt == 4'h0;
   endproperty
   a_tx_every16: assert property (p_tx_every16) else $error("Bit tick not on sixteenth sample");

   property p_period;
      RX_SAMPLE_TICK && seen |-> gap == per_cyc;
   endproperty
   a_period: assert property (p_period) else $error("Sample tick period wrong");

   property p_pd13;
      RX_SAMPLE_TICK && seen && sel == 5'h18 |-> gap == 14'h0034;
   endproperty
   a_pd13: assert property (p_pd13) else $error("Prescaler 13 period wrong");

   property p_bd128;
      RX_SAMPLE_TICK && seen && sel == 5'h07 |-> gap == 14'h0200;
   endproperty
   a_bd128: assert property (p_bd128) else $error("Divisor 128 period wrong");

   property p_single;
      RX_SAMPLE_TICK |=> !RX_SAMPLE_TICK [*3];
   endproperty
   a_single: assert property (p_single) else $error("Sample tick longer than one cycle");

   property p_reset_sel;
      rst_d |-> sel == 5'h00;
   endproperty
   a_reset_sel: assert property (p_reset_sel) else $error("Selects not cleared by reset");

   property p_write_sel;
      wr_ctrl |=> sel == $past(PWDATA[4:0]);
   endproperty
   a_write_sel: assert property (p_write_sel) else $error("Control write not stored");

   property p_read_sel;
      PREADY && !PWRITE && hit_ctrl |-> PRDATA == {27'h0, sel};
   endproperty
   a_read_sel: assert property (p_read_sel) else $error("Control readback wrong");

   // Only a control write with byte 0 enabled may move the selects
   property p_keep_sel;
      !wr_ctrl |=> $stable(sel);
   endproperty
   a_keep_sel: assert property (p_keep_sel) else $error("Selects changed without a write");

   property p_reload_quiet;
      reload |=> !RX_SAMPLE_TICK && !TX_BIT_TICK && pre_cnt == 6'h00 && bd_cnt == 7'h00 && os_cnt == 4'h0;
   endproperty
   a_reload_quiet: assert property (p_reload_quiet) else $error("Counters not restarted by rate change");

   property p_tx_single;
      TX_BIT_TICK |=> !TX_BIT_TICK;
   endproperty
   a_tx_single: assert property (p_tx_single) else $error("Bit tick longer than one cycle");
endmodule // sbrg_top

//--- sbrg_partner.sv
`timescale 1ns/1ps
// =====================================================
// Shift logic stand-in: measures tick spacing
// =====================================================
module sbrg_partner (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Ticks from the generator
   input wire logic rx_tick,
   input wire logic tx_tick,
   // Measurements
   output int rx_gap,
   output int tx_gap,
   output int rx_count,
   output int tx_odd
);
   int rc;
   int tc;
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         rc <= 0;
         tc <= 0;
         rx_gap <= 0;
         tx_gap <= 0;
         rx_count <= 0;
         tx_odd <= 0;
      end
      else
      begin
         rc <= rc + 1;
         tc <= tc + 1;
         if (rx_tick)
         begin
            rx_gap <= rc + 1;
            rc <= 0;
            rx_count <= rx_count + 1;
         end
         // Bit clock must sit on a sample tick
         if (tx_tick)
         begin
            tx_gap <= tc + 1;
            tc <= 0;
            if (!rx_tick)
               tx_odd <= tx_odd + 1;
         end
      end
   end
endmodule // sbrg_partner

//--- sci_baud_rate_generator_bench.sv
`timescale 1ns/1ps
module sci_baud_rate_generator_bench;
   logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, prdy, perr, rxt, txt, e;
   logic [11:0] pa = 12'h000;
   logic [31:0] pwd = 32'h0, rd, prd;
   int n_errors = 0, cmp_count = 0, rg, tg, rc, to, b;
   logic [3:0] pst = 4'hf;
   int pdt[4] = '{1, 3, 4, 13};
   sbrg_top dut (.CORE_CLK(clk), .RESET(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa),
      .PWDATA(pwd), .PSTRB(pst), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr), .RX_SAMPLE_TICK(rxt),
      .TX_BIT_TICK(txt));
   sbrg_partner far (.clk(clk), .rst(rst), .rx_tick(rxt), .tx_tick(txt), .rx_gap(rg), .tx_gap(tg),
      .rx_count(rc), .tx_odd(to));
   initial forever #5 clk = ~clk;
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // =====================================================
   // APB master: hold request until ready is sampled
   // =====================================================
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1;
      do
      begin
         @(posedge clk);
      end
      while (prdy !== 1'b1);
      rd = prd;
      e = perr;
      psel <= 0;
      pen <= 0;
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      #800_000;
      n_errors++;
      tally_and_finish;
   end
   initial
   begin
      void'($urandom(90466));
      repeat (6) @(posedge clk);
      rst <= 0;
      apb(0, sbrg_pkg::RATE_CTRL_OFFSET, 32'h0);
      chk("ctrl reset", rd, {24'h0, sbrg_pkg::RATE_CTRL_RESET});
      apb(0, 12'h008 + 12'($urandom % 1022) * 12'h004, 32'h0);
      chk("unmapped err", {31'h0, e}, 32'h1);
      chk("unmapped data", rd, 32'h0);
      pst <= 4'he;
      apb(1, sbrg_pkg::RATE_CTRL_OFFSET, 32'h0000_0015);
      pst <= 4'hf;
      apb(0, sbrg_pkg::RATE_CTRL_OFFSET, 32'h0);
      chk("ctrl no strobe", rd, {24'h0, sbrg_pkg::RATE_CTRL_RESET});
      $display("test reset_and_map done");
      // Every prescaler and divisor code, random junk above the fields
      for (int p = 0; p < 4; p++)
         for (int s = 0; s < 8; s++)
         begin
            apb(1, sbrg_pkg::RATE_CTRL_OFFSET, ($urandom & 32'hffffffe0) | 32'(p * 8 + s));
            b = rc;
            apb(0, sbrg_pkg::RATE_CTRL_OFFSET, 32'h0);
            chk("ctrl readback", rd, 32'(p * 8 + s));
            // An old tick may land on the write edge; three ticks leave one clean gap
            while (rc < b + 3)
            begin
               @(posedge clk);
            end
            chk("rx period", 32'(rg), 32'(4 * pdt[p] * (1 << s)));
         end
      $display("test rate_table done");
      apb(1, sbrg_pkg::RATE_CTRL_OFFSET, 32'h0);
      apb(0, sbrg_pkg::RATE_STATUS_OFFSET, 32'h0);
      chk("status after restart", rd, 32'h0);
      repeat (200) @(posedge clk);
      chk("tx period", 32'(tg), 32'h0000_0040);
      chk("tx off sample tick", 32'(to), 32'h0);
      $display("test bit_tick done");
      tally_and_finish;
   end
endmodule // sci_baud_rate_generator_bench
